// ### core/mvx_core.sv
// Purpose: management-mode entry/resume and management-mode virtual-machine exit control
// Assumes: inputs synchronous to pclk; registers reached over apb
// Notes: event inputs are one-cycle pulses; architectural state comes in on ports
`default_nettype none
module mvx_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mgmt_interrupt,
  input wire logic io_retired,
  input wire logic [2:0] io_size,
  input wire logic io_in,
  input wire logic io_string,
  input wire logic io_rep,
  input wire logic io_imm,
  input wire logic [15:0] io_port,
  input wire logic io_seg_usable,
  input wire logic [31:0] io_lin_addr,
  input wire logic [31:0] io_count_reg,
  input wire logic [31:0] io_source_index_reg,
  input wire logic [31:0] io_dest_index_reg,
  input wire logic [31:0] io_instruction_pointer,
  input wire logic [1:0] stack_privilege_level,
  input wire logic v86_flag,
  input wire logic blk_set_stack,
  input wire logic win_exit_ctl,
  input wire logic win_cond,
  input wire logic nmi_blk_saved,
  input wire logic saved_ve_image,
  input wire logic [31:0] saved_map_base,
  output logic virt_enable_bit,
  output logic in_mgmt_mode,
  output logic blk_mgmt_int,
  output logic blk_nmi,
  output logic blk_init,
  output logic blk_a20,
  output logic force_cr0,
  output logic [1:0] code_requested_priv,
  output logic [1:0] stack_requested_priv,
  output logic shutdown,
  output logic gp_fault,
  output logic save_to_ram,
  output logic win_vm_exit
);
  typedef struct packed {
    mvx_pkg::mvx_state_t st;
    logic ve;
    logic virt;
    logic nonroot;
    logic sv_ve;
    logic sv_virt;
    logic sv_nonroot;
    logic [1:0] sv_spl;
    logic sv_v86;
    logic sv_blk;
    logic [31:0] sv_ptr;
    logic [31:0] cur_ptr;
    logic [31:0] exec_ptr;
    logic [31:0] xfer_ptr;
    logic [31:0] on_ptr;
    logic mon_valid;
    logic dual;
    logic [31:0] base;
    logic [31:0] guest_base;
    logic [31:0] reason;
    logic [31:0] qual;
    logic [31:0] lin;
    logic [31:0] io_cnt;
    logic [31:0] io_src;
    logic [31:0] io_dst;
    logic [31:0] io_ip;
    logic b_int;
    logic b_nmi;
    logic b_init;
    logic b_a20;
    logic cr0;
    logic [1:0] crpl;
    logic [1:0] srpl;
    logic gp;
    logic save;
    logic win;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } mvx_regs_t;

  mvx_regs_t q, d;

  function automatic logic [31:0] rd_mux(input mvx_regs_t r, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      mvx_pkg::OFF_STATUS: begin
        v[mvx_pkg::S_MGMT] = (r.st == mvx_pkg::MVX_MGMT);
        v[mvx_pkg::S_VIRT] = r.virt;
        v[mvx_pkg::S_NONROOT] = r.nonroot;
        v[mvx_pkg::S_VE] = r.ve;
        v[mvx_pkg::S_BLK_INT] = r.b_int;
        v[mvx_pkg::S_BLK_NMI] = r.b_nmi;
        v[mvx_pkg::S_BLK_INIT] = r.b_init;
        v[mvx_pkg::S_BLK_A20] = r.b_a20;
        v[mvx_pkg::S_SHUTDOWN] = (r.st == mvx_pkg::MVX_SHUT);
        v[mvx_pkg::S_GP] = r.gp;
        v[mvx_pkg::S_WIN_EXIT] = r.win;
      end
      mvx_pkg::OFF_CTRL: v[mvx_pkg::C_DUAL] = r.dual;
      mvx_pkg::OFF_MON_CTL: v = r.on_ptr & 32'hffff_f000 | {31'h0, r.mon_valid};
      mvx_pkg::OFF_BASE: v = r.base;
      mvx_pkg::OFF_REASON: v = r.reason;
      mvx_pkg::OFF_QUAL_LO: v = r.qual;
      mvx_pkg::OFF_QUAL_HI: v = 32'h0000_0000;
      mvx_pkg::OFF_EXEC_PTR: v = r.exec_ptr;
      mvx_pkg::OFF_CUR_PTR: v = r.cur_ptr;
      mvx_pkg::OFF_XFER_PTR: v = r.xfer_ptr;
      mvx_pkg::OFF_ON_PTR: v = r.on_ptr;
      mvx_pkg::OFF_IO_CNT: v = r.io_cnt;
      mvx_pkg::OFF_IO_SRC: v = r.io_src;
      mvx_pkg::OFF_IO_DST: v = r.io_dst;
      mvx_pkg::OFF_IO_IP: v = r.io_ip;
      mvx_pkg::OFF_LIN_ADDR: v = r.lin;
      mvx_pkg::OFF_SAVED_BASE: v = r.base;
      mvx_pkg::OFF_GUEST_BASE: v = r.guest_base;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= mvx_pkg::OFF_GUEST_BASE);
  endfunction

  logic acc, wr;
  logic [31:0] ctl_w;
  logic ev_int, ev_io, ev_call, ev_resume, ev_set_ve, ev_init, ev_iret;
  logic ev_virt_on, ev_guest;
  logic in_mode, do_exit, do_default;

  always_comb begin
    d = q;
    acc = psel && penable && !q.ready;
    wr = acc && pwrite;
    ctl_w = (wr && paddr == mvx_pkg::OFF_CTRL) ? pwdata : 32'h0000_0000;
    ev_int = mgmt_interrupt || ctl_w[mvx_pkg::C_INT];
    ev_io = (ev_int && io_retired) || ctl_w[mvx_pkg::C_IO_INT];
    ev_call = ctl_w[mvx_pkg::C_MON_CALL];
    ev_resume = ctl_w[mvx_pkg::C_RESUME];
    ev_set_ve = ctl_w[mvx_pkg::C_SET_VE];
    ev_init = ctl_w[mvx_pkg::C_INIT];
    ev_iret = ctl_w[mvx_pkg::C_IRET];
    ev_virt_on = ctl_w[mvx_pkg::C_VIRT_ON];
    ev_guest = ctl_w[mvx_pkg::C_GUEST];
    in_mode = (q.st == mvx_pkg::MVX_MGMT);
    d.save = 1'b0;
    d.win = 1'b0;
    d.ready = acc;
    d.err = acc && !known(paddr);
    d.rdata = acc ? rd_mux(q, paddr) : 32'h0000_0000;
    if (wr) begin
      case (paddr)
        mvx_pkg::OFF_CTRL: d.dual = pwdata[mvx_pkg::C_DUAL];
        mvx_pkg::OFF_MON_CTL: d.mon_valid = pwdata[0];
        mvx_pkg::OFF_CUR_PTR: d.cur_ptr = pwdata;
        mvx_pkg::OFF_XFER_PTR: d.xfer_ptr = pwdata;
        mvx_pkg::OFF_ON_PTR: d.on_ptr = pwdata;
        default: d.dual = q.dual;
      endcase
    end
    do_exit = q.st == mvx_pkg::MVX_RUN && ((ev_int && !q.b_int && q.dual)
      || (ev_call && q.virt && !q.nonroot && q.mon_valid));
    do_default = q.st == mvx_pkg::MVX_RUN && ev_int && !q.b_int && !q.dual && !do_exit;
    case (q.st)
      mvx_pkg::MVX_RUN: begin
        if (ev_set_ve) d.ve = 1'b1;
        if (ev_iret) d.b_nmi = 1'b0;
        // virtualization operation needs the enable bit; guests only from root
        if (ev_virt_on && q.ve) d.virt = 1'b1;
        if (ev_guest && q.virt) d.nonroot = 1'b1;
        if (do_exit) begin
          // direct transfer, no save into management ram
          d.save = 1'b0;
          d.exec_ptr = q.nonroot ? q.cur_ptr : q.on_ptr;
          d.cur_ptr = q.xfer_ptr;
          d.reason = 32'h0000_0000;
          d.reason[15:0] = ev_call && !ev_int ? mvx_pkg::RSN_MON_CALL
            : (ev_io ? mvx_pkg::RSN_IO_INT : mvx_pkg::RSN_OTHER_INT);
          d.reason[mvx_pkg::RSN_ROOT_BIT] = !q.nonroot;
          d.qual = 32'h0000_0000;
          if (ev_int && ev_io) begin
            d.qual[mvx_pkg::Q_SIZE_LSB +: 3] = io_size;
            d.qual[mvx_pkg::Q_DIR] = io_in;
            d.qual[mvx_pkg::Q_STR] = io_string;
            d.qual[mvx_pkg::Q_REP] = io_rep;
            d.qual[mvx_pkg::Q_IMM] = io_imm;
            d.qual[mvx_pkg::Q_PORT_LSB +: 16] = io_port;
            d.io_cnt = io_count_reg;
            d.io_src = io_source_index_reg;
            d.io_dst = io_dest_index_reg;
            d.io_ip = io_instruction_pointer;
            if (io_string && io_seg_usable) d.lin = io_lin_addr;
          end
          d.guest_base = q.base;
          d.b_nmi = 1'b1;
          d.b_int = 1'b1;
          d.nonroot = 1'b0;
        end else if (do_default) begin
          d.sv_ve = q.ve;
          d.sv_virt = q.virt;
          d.sv_nonroot = q.nonroot;
          if (q.virt) begin
            d.sv_ptr = q.cur_ptr;
            d.sv_spl = stack_privilege_level;
            d.sv_v86 = v86_flag;
            d.sv_blk = blk_set_stack;
          end
          d.virt = 1'b0;
          d.nonroot = 1'b0;
          d.ve = 1'b0;
          d.save = 1'b1;
          d.b_init = 1'b1;
          d.b_nmi = 1'b1;
          d.b_int = 1'b1;
          d.st = mvx_pkg::MVX_MGMT;
        end
      end
      mvx_pkg::MVX_MGMT: begin
        if (ev_set_ve) d.gp = 1'b1;
        if (ev_resume) begin
          if (saved_ve_image) begin
            d.st = mvx_pkg::MVX_SHUT;
          end else begin
            d.st = mvx_pkg::MVX_RUN;
            d.base = saved_map_base;
            d.ve = q.sv_ve;
            d.virt = q.sv_virt;
            d.nonroot = q.sv_virt && q.sv_nonroot;
            d.b_int = 1'b0;
            d.b_nmi = nmi_blk_saved;
            d.b_init = q.sv_virt && !q.sv_nonroot;
            if (q.sv_virt) begin
              d.cur_ptr = q.sv_ptr;
              d.cr0 = 1'b1;
              if (!q.sv_v86) begin
                d.crpl = q.sv_spl;
                d.srpl = q.sv_spl;
              end
              d.b_a20 = 1'b1;
              d.win = q.sv_nonroot && win_exit_ctl && win_cond;
            end else begin
              d.b_a20 = 1'b0;
            end
          end
        end
      end
      mvx_pkg::MVX_SHUT: d.st = mvx_pkg::MVX_SHUT;
      default: d.st = mvx_pkg::MVX_RUN;
    endcase
    if (ctl_w[mvx_pkg::C_SET_VE] == 1'b0 && wr && paddr == mvx_pkg::OFF_STATUS) d.gp = 1'b0;
    if (ev_init) begin
      d.base = q.base;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= mvx_pkg::MVX_RUN;
      q.base <= mvx_pkg::BASE_RESET;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign virt_enable_bit = q.ve;
  assign in_mgmt_mode = (q.st == mvx_pkg::MVX_MGMT);
  assign blk_mgmt_int = q.b_int;
  assign blk_nmi = q.b_nmi;
  assign blk_init = q.b_init;
  assign blk_a20 = q.b_a20;
  assign force_cr0 = q.cr0;
  assign code_requested_priv = q.crpl;
  assign stack_requested_priv = q.srpl;
  assign shutdown = (q.st == mvx_pkg::MVX_SHUT);
  assign gp_fault = q.gp;
  assign save_to_ram = q.save;
  assign win_vm_exit = q.win;
endmodule
`default_nettype wire

// ### core/mvx_pkg.sv
// Purpose: shared constants for the management-mode / virtualization entry-exit unit
// Assumes: APB register access, 32-bit data
// Notes: offsets are byte addresses
`default_nettype none
package mvx_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MON_CTL = 8'h08;
  localparam logic [7:0] OFF_BASE = 8'h0c;
  localparam logic [7:0] OFF_REASON = 8'h10;
  localparam logic [7:0] OFF_QUAL_LO = 8'h14;
  localparam logic [7:0] OFF_QUAL_HI = 8'h18;
  localparam logic [7:0] OFF_EXEC_PTR = 8'h1c;
  localparam logic [7:0] OFF_CUR_PTR = 8'h20;
  localparam logic [7:0] OFF_XFER_PTR = 8'h24;
  localparam logic [7:0] OFF_ON_PTR = 8'h28;
  localparam logic [7:0] OFF_IO_CNT = 8'h2c;
  localparam logic [7:0] OFF_IO_SRC = 8'h30;
  localparam logic [7:0] OFF_IO_DST = 8'h34;
  localparam logic [7:0] OFF_IO_IP = 8'h38;
  localparam logic [7:0] OFF_LIN_ADDR = 8'h3c;
  localparam logic [7:0] OFF_SAVED_BASE = 8'h40;
  localparam logic [7:0] OFF_GUEST_BASE = 8'h44;
  localparam logic [31:0] BASE_RESET = 32'h0003_0000;
  // exit reason codes
  localparam logic [15:0] RSN_IO_INT = 16'h0005;
  localparam logic [15:0] RSN_OTHER_INT = 16'h0006;
  localparam logic [15:0] RSN_MON_CALL = 16'h0012;
  localparam int RSN_ROOT_BIT = 29;
  // qualification field positions
  localparam int Q_SIZE_LSB = 0;
  localparam int Q_DIR = 3;
  localparam int Q_STR = 4;
  localparam int Q_REP = 5;
  localparam int Q_IMM = 6;
  localparam int Q_PORT_LSB = 16;
  // control register bits (software events, write 1 pulses; C_DUAL is a stored mode bit, not a pulse)
  localparam int C_INT = 0;
  localparam int C_IO_INT = 1;
  localparam int C_MON_CALL = 2;
  localparam int C_RESUME = 3;
  localparam int C_SET_VE = 4;
  localparam int C_INIT = 5;
  localparam int C_IRET = 6;
  localparam int C_DUAL = 7;
  // enter root, then non-root, virtualization operation
  localparam int C_VIRT_ON = 8;
  localparam int C_GUEST = 9;
  // status bits
  localparam int S_MGMT = 0;
  localparam int S_VIRT = 1;
  localparam int S_NONROOT = 2;
  localparam int S_VE = 3;
  localparam int S_BLK_INT = 4;
  localparam int S_BLK_NMI = 5;
  localparam int S_BLK_INIT = 6;
  localparam int S_BLK_A20 = 7;
  localparam int S_SHUTDOWN = 8;
  localparam int S_GP = 9;
  localparam int S_WIN_EXIT = 10;
  typedef enum logic [1:0] {MVX_RUN, MVX_MGMT, MVX_SHUT} mvx_state_t;
endpackage
`default_nettype wire

// ### sim/mvx_core_sva.sv
// Purpose: port assertions for mvx_core
// Assumes: one clock pclk, async active-low presetn
// Notes: bound to every mvx_core below
`default_nettype none
module mvx_core_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nmi_blk_saved,
  input wire logic virt_enable_bit,
  input wire logic in_mgmt_mode,
  input wire logic blk_mgmt_int,
  input wire logic blk_nmi,
  input wire logic blk_init,
  input wire logic shutdown,
  input wire logic gp_fault,
  input wire logic save_to_ram,
  input wire logic win_vm_exit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_entry_blocks: assert property ($rose(in_mgmt_mode) |-> blk_init && blk_nmi && blk_mgmt_int)
    else $error("entry left an event unblocked");
  a_shutdown_holds: assert property (shutdown |=> shutdown)
    else $error("shutdown left without reset");
  a_save_clean: assert property (save_to_ram |-> !virt_enable_bit ##1 !save_to_ram)
    else $error("state save with enable bit set or not a pulse");
  a_gp_in_mode: assert property ($rose(gp_fault) |-> in_mgmt_mode)
    else $error("fault raised outside management mode");
  a_resume_unblock: assert property ($fell(in_mgmt_mode) && !shutdown
    |-> !blk_mgmt_int && blk_nmi == $past(nmi_blk_saved))
    else $error("resume blocking state wrong");
  a_win_pulse: assert property (win_vm_exit |=> !win_vm_exit)
    else $error("window exit longer than one cycle");
  cover property ($rose(in_mgmt_mode));
  cover property ($rose(shutdown));
  cover property ($rose(blk_mgmt_int) && !in_mgmt_mode);
endmodule
bind mvx_core mvx_core_sva i_sva (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .nmi_blk_saved, .virt_enable_bit, .in_mgmt_mode, .blk_mgmt_int, .blk_nmi, .blk_init,
  .shutdown, .gp_fault, .save_to_ram, .win_vm_exit);
`default_nettype wire

// ### sim/mvx_platform.sv
// Purpose: platform logic raising the management interrupt
// Assumes: req is a one-cycle pulse from the bench
// Notes: lag sets cycles before the one-cycle interrupt pulse
`default_nettype none
module mvx_platform (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [3:0] lag,
  output logic mgmt_interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      mgmt_interrupt <= 1'b0;
    end else begin
      mgmt_interrupt <= (cnt_q == 5'h01);
      if (req) cnt_q <= {1'b0, lag} + 5'h01;
      else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule
`default_nettype wire

// ### sim/mvx_core_bench.sv
// Purpose: self-checking bench for mvx_core
// Assumes: apb answers with one wait state
// Notes: reads queue notes that a watcher compares
`default_nettype none
module mvx_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} mvx_note_t;
  mvx_note_t notes[$];
  mvx_note_t n;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int saves = 0;
  int wins = 0;
  logic [31:0] rnd = 32'haf138555;
  logic [31:0] base;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, req, mgmt_interrupt;
  logic [3:0] lag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, io_lin_addr, io_count_reg, io_source_index_reg;
  logic [31:0] io_dest_index_reg, io_instruction_pointer, saved_map_base;
  logic io_retired, io_in, io_string, io_rep, io_imm, io_seg_usable;
  logic [2:0] io_size;
  logic [15:0] io_port;
  logic [1:0] stack_privilege_level, code_requested_priv, stack_requested_priv;
  logic v86_flag, blk_set_stack, win_exit_ctl, win_cond, nmi_blk_saved, saved_ve_image;
  logic virt_enable_bit, in_mgmt_mode, blk_mgmt_int, blk_nmi, blk_init, blk_a20;
  logic force_cr0, shutdown, gp_fault, save_to_ram, win_vm_exit;
  mvx_core i_dut (.*);
  mvx_platform i_plat (.pclk(pclk), .presetn(presetn), .req(req), .lag(lag),
    .mgmt_interrupt(mgmt_interrupt));
  always #10 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    notes.push_back('{d, m, 1'b0});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic fire(input logic [3:0] l);
    int k;
    k = 0;
    req <= 1'b1;
    lag <= l;
    @(posedge pclk);
    req <= 1'b0;
    while (in_mgmt_mode !== 1'b1 && blk_mgmt_int !== 1'b1 && k < 30) begin
      @(posedge pclk);
      k++;
    end
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (save_to_ram === 1'b1) saves++;
    if (win_vm_exit === 1'b1) wins++;
    if (cycles > 3000) begin
      errors++;
      stop_test();
    end
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      n = notes.pop_front();
      chk(prdata & n.m, n.d & n.m);
      chk({31'h0, pslverr}, {31'h0, n.e});
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, req, lag, paddr, pwdata, io_lin_addr} = '0;
    {io_count_reg, io_source_index_reg, io_dest_index_reg, io_instruction_pointer} = '0;
    {io_retired, io_in, io_string, io_rep, io_imm, io_seg_usable, io_size, io_port} = '0;
    {saved_map_base, stack_privilege_level, v86_flag, blk_set_stack} = '0;
    {win_exit_ctl, win_cond, nmi_blk_saved, saved_ve_image} = '0;
    do_reset();
    rd(mvx_pkg::OFF_BASE, mvx_pkg::BASE_RESET, '1);
    notes.push_back('{32'h0, 32'h0, 1'b1});
    xfer(1'b0, 8'h4c, 32'h0);
    {stack_privilege_level, v86_flag, blk_set_stack, win_exit_ctl, win_cond} <= rnd[5:0];
    fire(4'h5);
    chk(saves, 32'h1);
    rd(mvx_pkg::OFF_STATUS, b(mvx_pkg::S_MGMT) | b(mvx_pkg::S_BLK_INT) | b(mvx_pkg::S_BLK_NMI)
      | b(mvx_pkg::S_BLK_INIT), '1);
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_SET_VE));
    rd(mvx_pkg::OFF_STATUS, b(mvx_pkg::S_GP), b(mvx_pkg::S_GP) | b(mvx_pkg::S_VE));
    chk({31'h0, gp_fault}, 32'h1);
    base = {rnd[31:15], 15'h0};
    saved_map_base <= base;
    nmi_blk_saved <= 1'b1;
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_RESUME));
    rd(mvx_pkg::OFF_BASE, base, '1);
    rd(mvx_pkg::OFF_STATUS, b(mvx_pkg::S_BLK_NMI), 32'h0000_0171);
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_INIT));
    rd(mvx_pkg::OFF_BASE, base, '1);
    rnd = lfsr(rnd);
    {io_count_reg, io_source_index_reg, io_dest_index_reg} <= {rnd, ~rnd, rnd ^ 32'h5a5a_5a5a};
    {io_instruction_pointer, io_lin_addr} <= {rnd[15:0], rnd, rnd[31:16]};
    {io_port, io_in, io_rep, io_imm} <= rnd[18:0];
    io_size <= rnd[20] ? 3'h3 : {2'h0, rnd[21]};
    {io_retired, io_string, io_seg_usable} <= 3'h7;
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_DUAL));
    fire(4'h0);
    rd(mvx_pkg::OFF_REASON, {16'h2000, mvx_pkg::RSN_IO_INT}, '1);
    rd(mvx_pkg::OFF_QUAL_LO, {io_port, 9'h0, io_imm, io_rep, io_string, io_in, io_size}, '1);
    rd(mvx_pkg::OFF_QUAL_HI, 32'h0, '1);
    rd(mvx_pkg::OFF_IO_CNT, io_count_reg, '1);
    rd(mvx_pkg::OFF_IO_SRC, io_source_index_reg, '1);
    rd(mvx_pkg::OFF_IO_DST, io_dest_index_reg, '1);
    rd(mvx_pkg::OFF_IO_IP, io_instruction_pointer, '1);
    rd(mvx_pkg::OFF_LIN_ADDR, io_lin_addr, '1);
    rd(mvx_pkg::OFF_GUEST_BASE, base, '1);
    rd(mvx_pkg::OFF_STATUS, 32'h0000_0030, 32'h0000_0031);
    chk(saves, 32'h1);
    do_reset();
    rd(mvx_pkg::OFF_BASE, mvx_pkg::BASE_RESET, '1);
    io_retired <= 1'b0;
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_DUAL));
    fire(4'h0);
    rd(mvx_pkg::OFF_REASON, {16'h2000, mvx_pkg::RSN_OTHER_INT}, '1);
    do_reset();
    rnd = lfsr(rnd);
    xfer(1'b1, mvx_pkg::OFF_CUR_PTR, rnd);
    xfer(1'b1, mvx_pkg::OFF_ON_PTR, ~rnd);
    xfer(1'b1, mvx_pkg::OFF_XFER_PTR, rnd ^ 32'h0f0f_0f0f);
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_SET_VE));
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_VIRT_ON));
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_GUEST));
    {stack_privilege_level, v86_flag, blk_set_stack, win_exit_ctl, win_cond} <= {rnd[9:8], 4'h3};
    nmi_blk_saved <= 1'b0;
    fire(4'h1);
    rd(mvx_pkg::OFF_STATUS, b(mvx_pkg::S_MGMT) | b(mvx_pkg::S_BLK_INT) | b(mvx_pkg::S_BLK_NMI)
      | b(mvx_pkg::S_BLK_INIT), '1);
    stack_privilege_level <= ~rnd[9:8];
    xfer(1'b1, mvx_pkg::OFF_CUR_PTR, 32'h0000_0000);
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_RESUME));
    rd(mvx_pkg::OFF_STATUS, b(mvx_pkg::S_VIRT) | b(mvx_pkg::S_NONROOT) | b(mvx_pkg::S_VE)
      | b(mvx_pkg::S_BLK_A20), '1);
    rd(mvx_pkg::OFF_CUR_PTR, rnd, '1);
    chk({27'h0, force_cr0, code_requested_priv, stack_requested_priv},
      {27'h0, 1'b1, rnd[9:8], rnd[9:8]});
    chk({26'h0, virt_enable_bit, in_mgmt_mode, blk_mgmt_int, blk_nmi, blk_init, blk_a20},
      32'h21);
    chk(wins, 32'h1);
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_DUAL));
    fire(4'h0);
    rd(mvx_pkg::OFF_EXEC_PTR, rnd, '1);
    rd(mvx_pkg::OFF_CUR_PTR, rnd ^ 32'h0f0f_0f0f, '1);
    rd(mvx_pkg::OFF_REASON, {16'h0, mvx_pkg::RSN_OTHER_INT}, '1);
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_IRET));
    rd(mvx_pkg::OFF_STATUS, b(mvx_pkg::S_BLK_INT), 32'h0000_0030);
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_MON_CALL));
    rd(mvx_pkg::OFF_REASON, {16'h0, mvx_pkg::RSN_OTHER_INT}, '1);
    xfer(1'b1, mvx_pkg::OFF_MON_CTL, 32'h0000_0001);
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_MON_CALL));
    rd(mvx_pkg::OFF_REASON, {16'h2000, mvx_pkg::RSN_MON_CALL}, '1);
    rd(mvx_pkg::OFF_EXEC_PTR, ~rnd, '1);
    do_reset();
    fire(4'h2);
    saved_ve_image <= 1'b1;
    xfer(1'b1, mvx_pkg::OFF_CTRL, b(mvx_pkg::C_RESUME));
    rd(mvx_pkg::OFF_STATUS, b(mvx_pkg::S_SHUTDOWN), b(mvx_pkg::S_SHUTDOWN));
    chk({30'h0, shutdown, gp_fault}, 32'h2);
    repeat (2) @(posedge pclk);
    stop_test();
  end
endmodule
`default_nettype wire
